// ===== hw/fdoc_defs.svh
// offsets, field positions, reset values and clock period counts of the divide output control
`ifndef FDOC_DEFS_SVH
`define FDOC_DEFS_SVH
// register byte offsets
`define FDOC_OFF_CTRL 12'h000
`define FDOC_OFF_STATUS 12'h004
`define FDOC_OFF_QLO 12'h008
`define FDOC_OFF_QHI 12'h00C
// control field positions and reset value
`define FDOC_CTRL_EN_BIT 0
`define FDOC_CTRL_RND_BIT 1
`define FDOC_CTRL_RST 2'h1
// clock periods counted from issue (CP00)
`define FDOC_CP_DIGIT0 5'h02
`define FDOC_CP_REL_FIRST 5'h02
`define FDOC_CP_REL_LAST 5'h11
`define FDOC_CP_ENTER_LOW_FIRST 5'h01
`define FDOC_CP_ENTER_LOW_LAST 5'h11
`define FDOC_CP_ROUND 5'h02
`define FDOC_CP_BLOCK 5'h0F
`define FDOC_CP_CLR_BUSY 5'h11
`define FDOC_CP_GATE 5'h12
`define FDOC_CP_LAST 5'h13
// datapath constants
`define FDOC_ROUND_DIGITS 15'h2AAA
`define FDOC_EXP_LIMIT 13'h03FF
`define FDOC_CORR_FRAC 6'h30
`define FDOC_CORR_INT 6'h2F
`define FDOC_SIGN_BIT 59
`endif

// ===== hw/fdoc_mult3.sv
// triple divisor adder: four 12-bit sections with carry lookahead
`timescale 1ns/1ps
`default_nettype none
module fdoc_mult3
  import fdoc_pkg::*;
(
  // divisor magnitude
  input wire logic [47:0] xk_i,
  // three times the divisor
  output logic [49:0] m3_o
);
  logic [48:0] x2;
  logic [3:0] sec_c;
  logic [3:0] sec_e;
  logic [4:0] look_c;
  logic [11:0] sec_sum [4];

  // doubled divisor by left shift
  assign x2 = {xk_i, 1'b0};

  // preliminary section adders give section carry and enable
  for (genvar s = 0; s < 4; s++) begin : g_sec
    logic [12:0] pre;
    assign pre = {1'b0, xk_i[s*12 +: 12]} + {1'b0, x2[s*12 +: 12]};
    assign sec_c[s] = pre[12];
    assign sec_e[s] = &pre[11:0];
    assign look_c[s+1] = sec_c[s] | (sec_e[s] & look_c[s]);
    assign sec_sum[s] = pre[11:0] + {11'h000, look_c[s]};
  end
  assign look_c[0] = 1'b0;

  // top two bits from the fourth section carry plus divisor bit 47
  assign m3_o = {{1'b0, xk_i[47]} + {1'b0, look_c[4]},
    sec_sum[3], sec_sum[2], sec_sum[1], sec_sum[0]};
endmodule
`default_nettype wire

// ===== hw/fdoc_pkg.sv
// types shared by the divide output control
package fdoc_pkg;
  // sequence states, gray along idle -> run
  typedef enum logic [1:0] {
    FDOC_IDLE = 2'h0,
    FDOC_RUN = 2'h1
  } fdoc_state_e;
  // quotient word as delivered to the destination register
  typedef struct packed {
    logic sign;
    logic [10:0] exp;
    logic [47:0] coef;
  } fdoc_quot_s;
  // special case flags sent with the quotient
  typedef struct packed {
    logic go_special;
    logic cplt_ovf;
    logic cplt_unf;
    logic fault;
  } fdoc_flags_s;
endpackage

// ===== hw/fdoc_top.sv
// divide sequence control, quotient output registers and divisor multiple path
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fdoc_defs.svh"
module fdoc_top
  import fdoc_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // axi4-lite write address and data
  input wire logic [11:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // axi4-lite read
  input wire logic [11:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // instruction issue and operands
  input wire logic BEGIN_I,
  input wire logic ROUND_I,
  input wire logic [59:0] DIVIDEND_OPERAND_I,
  input wire logic [59:0] DIVISOR_OPERAND_I,
  // iteration and exponent networks
  input wire logic [2:0] DIGIT_I,
  input wire logic [47:0] REM_HELD_I,
  input wire logic [10:0] EXP_CMP_I,
  input wire logic signed [12:0] EXP_UNB_I,
  input wire logic SPECIAL_I,
  input wire logic INDEF_I,
  // iteration network controls
  output logic RELEASE_REM_O,
  output logic CIRC_REM_O,
  output logic [47:0] REM_SRC_O,
  output logic [49:0] MULT3_O,
  output logic [50:0] MULT6_O,
  output logic [5:0] EXPONENT_CORRECTION_O,
  // destination register input control
  output fdoc_quot_s QUOT_O,
  output fdoc_flags_s FLAGS_O,
  output logic GATE_QUOT_O,
  output logic QUOT_VALID_O,
  output logic ISSUE_BLOCK_TIMING_O,
  output logic CLR_BUSY_O
);
  fdoc_state_e state_reg;
  logic [4:0] cp_reg;
  logic [1:0] ctrl_reg;
  logic begin_ok;
  logic run;
  logic [4:0] cur_cp;
  logic round_reg;
  logic [47:0] sr_reg;
  logic [47:0] sr_next;
  logic ovf_reg;
  logic fault_reg;
  logic cplt_ovf;
  logic cplt_unf;
  logic special;
  logic gate_q;
  logic enter_divisor;
  logic [47:0] divisor_reg;
  logic [47:0] dividend_reg;
  logic [49:0] m3;
  logic [49:0] m3_reg;
  fdoc_quot_s quot_reg;
  fdoc_flags_s flags_reg;
  logic [11:0] awaddr_reg;
  logic aw_have_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_have_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // magnitude of a signed-coefficient operand
  function automatic logic [47:0] fdoc_mag(input logic [59:0] op);
    fdoc_mag = op[`FDOC_SIGN_BIT] ? ~op[47:0] : op[47:0];
  endfunction

  // true when the sequence stands in clock period n
  function automatic logic fdoc_at(input logic [4:0] n, input logic act,
    input logic [4:0] cp);
    fdoc_at = act && (cp == n);
  endfunction

  // sequence position: CP00 is the issue cycle itself
  assign run = (state_reg == FDOC_RUN);
  assign begin_ok = BEGIN_I && ctrl_reg[`FDOC_CTRL_EN_BIT] && !run;
  assign cur_cp = run ? cp_reg : 5'h00;

  // divide sequence control
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      state_reg <= FDOC_IDLE;
      cp_reg <= 5'h00;
    end else if (begin_ok) begin
      state_reg <= FDOC_RUN;
      cp_reg <= 5'h01;
    end else if (run) begin
      case (state_reg)
        FDOC_RUN: begin
          if (cp_reg == `FDOC_CP_LAST) begin
            state_reg <= FDOC_IDLE;
            cp_reg <= 5'h00;
          end else begin
            cp_reg <= cp_reg + 5'h01;
          end
        end
        default: state_reg <= FDOC_IDLE;
      endcase
    end
  end

  // timing conditions toward issue, register access control and the iteration network
  assign ISSUE_BLOCK_TIMING_O = fdoc_at(`FDOC_CP_BLOCK, run, cur_cp);
  assign CLR_BUSY_O = fdoc_at(`FDOC_CP_CLR_BUSY, run, cur_cp);
  assign RELEASE_REM_O = run && (cp_reg >= `FDOC_CP_REL_FIRST)
    && (cp_reg <= `FDOC_CP_REL_LAST);
  assign CIRC_REM_O = run && (cp_reg >= `FDOC_CP_DIGIT0);

  // round flag set at issue of a rounded divide
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      round_reg <= 1'b0;
    end else if (begin_ok) begin
      round_reg <= ROUND_I | ctrl_reg[`FDOC_CTRL_RND_BIT];
    end else if (!run) begin
      round_reg <= 1'b0;
    end
  end

  // dividend input register, captured in CP00
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      dividend_reg <= 48'h000000000000;
    end else if (begin_ok) begin
      dividend_reg <= fdoc_mag(DIVIDEND_OPERAND_I);
    end
  end

  // source for final subtraction, with round digits in the third clock
  always_comb begin
    REM_SRC_O = CIRC_REM_O ? REM_HELD_I : dividend_reg;
    if (fdoc_at(`FDOC_CP_ROUND, run, cur_cp) && round_reg) begin
      REM_SRC_O[14:0] = `FDOC_ROUND_DIGITS;
    end
  end

  // divisor input register: enter low from CP01 through CP17
  assign enter_divisor = !(run && (cp_reg >= `FDOC_CP_ENTER_LOW_FIRST)
    && (cp_reg <= `FDOC_CP_ENTER_LOW_LAST));
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      divisor_reg <= 48'h000000000000;
    end else if (enter_divisor) begin
      divisor_reg <= fdoc_mag(DIVISOR_OPERAND_I);
    end
  end

  // triple multiple adder
  fdoc_mult3 u_mult3 (
    .xk_i(divisor_reg),
    .m3_o(m3)
  );

  // registered triple and six-times multiples
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      m3_reg <= 50'h0000000000000;
    end else begin
      m3_reg <= m3;
    end
  end
  assign MULT3_O = m3_reg;
  assign MULT6_O = {m3_reg, 1'b0};

  // quotient shift register: three bits in, top three dropped
  assign sr_next = {sr_reg[44:0], DIGIT_I};
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      sr_reg <= 48'h000000000000;
    end else if (run && (cp_reg >= `FDOC_CP_DIGIT0) && (cp_reg <= `FDOC_CP_GATE)) begin
      sr_reg <= sr_next;
    end
  end

  // first digit: overflow and divide fault bits
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      ovf_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else if (fdoc_at(`FDOC_CP_DIGIT0, run, cur_cp)) begin
      ovf_reg <= DIGIT_I[0];
      fault_reg <= DIGIT_I[1];
    end
  end
  assign EXPONENT_CORRECTION_O = ovf_reg ? `FDOC_CORR_INT : `FDOC_CORR_FRAC;

  // quotient exponent range: exactly 1777 octal stays normal
  assign cplt_ovf = (EXP_UNB_I > $signed(`FDOC_EXP_LIMIT)) && !INDEF_I;
  assign cplt_unf = (EXP_UNB_I < -$signed(`FDOC_EXP_LIMIT)) && !INDEF_I;
  assign special = SPECIAL_I || cplt_ovf || cplt_unf || fault_reg;
  assign gate_q = fdoc_at(`FDOC_CP_GATE, run, cur_cp) && !special;
  assign GATE_QUOT_O = gate_q;

  // output registers loaded at the end of CP18, shown in CP19
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      quot_reg <= '0;
      flags_reg <= '0;
    end else if (fdoc_at(`FDOC_CP_GATE, run, cur_cp)) begin
      quot_reg.sign <= gate_q ? 1'b0 : 1'b1;
      quot_reg.exp <= gate_q ? ~EXP_CMP_I : 11'h7FF;
      if (!gate_q) begin
        quot_reg.coef <= 48'hFFFFFFFFFFFF;
      end else if (ovf_reg) begin
        quot_reg.coef <= {1'b1, sr_next[47:1]};
      end else begin
        quot_reg.coef <= sr_next;
      end
      flags_reg.go_special <= !gate_q;
      flags_reg.cplt_ovf <= cplt_ovf;
      flags_reg.cplt_unf <= cplt_unf;
      flags_reg.fault <= fault_reg;
    end
  end
  assign QUOT_O = quot_reg;
  assign FLAGS_O = flags_reg;
  assign QUOT_VALID_O = fdoc_at(`FDOC_CP_LAST, run, cur_cp);

  // axi write address and data holding, either order
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_have_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA_I;
        wstrb_reg <= S_AXI_WSTRB_I;
      end
      if (aw_have_reg && w_have_reg) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
    end
  end
  assign S_AXI_AWREADY_O = !aw_have_reg && !bvalid_reg;
  assign S_AXI_WREADY_O = !w_have_reg && !bvalid_reg;

  // control register write and write response
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      ctrl_reg <= `FDOC_CTRL_RST;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end else if (aw_have_reg && w_have_reg) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= 2'h0;
      case (awaddr_reg[11:2])
        `FDOC_OFF_CTRL >> 2: begin
          if (wstrb_reg[0]) begin
            ctrl_reg <= wdata_reg[1:0];
          end
        end
        `FDOC_OFF_STATUS >> 2, `FDOC_OFF_QLO >> 2, `FDOC_OFF_QHI >> 2: bresp_reg <= 2'h0;
        default: bresp_reg <= 2'h2;
      endcase
    end else if (bvalid_reg && S_AXI_BREADY_I) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign S_AXI_BVALID_O = bvalid_reg;
  assign S_AXI_BRESP_O = bresp_reg;

  // register reads
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= 2'h0;
      case (S_AXI_ARADDR_I[11:2])
        `FDOC_OFF_CTRL >> 2: rdata_reg <= {30'h00000000, ctrl_reg};
        `FDOC_OFF_STATUS >> 2: rdata_reg <= {20'h00000, flags_reg, round_reg, ovf_reg,
          run, cp_reg};
        `FDOC_OFF_QLO >> 2: rdata_reg <= quot_reg[31:0];
        `FDOC_OFF_QHI >> 2: rdata_reg <= {4'h0, quot_reg[59:32]};
        default: begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= 2'h2;
        end
      endcase
    end else if (rvalid_reg && S_AXI_RREADY_I) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign S_AXI_ARREADY_O = !rvalid_reg;
  assign S_AXI_RVALID_O = rvalid_reg;
  assign S_AXI_RDATA_O = rdata_reg;
  assign S_AXI_RRESP_O = rresp_reg;

  // checks on the sequence and output path
  default clocking fdoc_cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence s_issue;
    begin_ok;
  endsequence
  sequence s_release_window;
    !RELEASE_REM_O ##1 !RELEASE_REM_O ##1 RELEASE_REM_O [*8];
  endsequence

  a_release_window: assert property (s_issue |-> s_release_window)
    else $error("release remainder window wrong");
  a_issue_block: assert property (s_issue |-> ##15 ISSUE_BLOCK_TIMING_O)
    else $error("issue block timing not in 16th clock");
  a_clear_busy: assert property (s_issue |-> ##17 CLR_BUSY_O ##3 !run)
    else $error("clear busy not in 18th clock");
  a_gate_when: assert property (GATE_QUOT_O |-> run && cp_reg == 5'h12)
    else $error("gate quotient outside CP18");
  a_fault_block: assert property (fault_reg && run && cp_reg == 5'h12 |-> !GATE_QUOT_O
    ##1 QUOT_O.coef == 48'hFFFFFFFFFFFF)
    else $error("faulted quotient not blocked");
  a_exp_ones: assert property (run && cp_reg == 5'h12 && !GATE_QUOT_O
    |=> {QUOT_O.sign, QUOT_O.exp} == 12'hFFF)
    else $error("special case exponent not all ones");
  a_sign_zero: assert property (GATE_QUOT_O |=> !QUOT_O.sign
    && QUOT_O.exp == ~$past(EXP_CMP_I))
    else $error("normal quotient sign or exponent wrong");
  a_coef_shift: assert property (GATE_QUOT_O && ovf_reg |=> QUOT_O.coef[47])
    else $error("overflow coefficient bit 47 not forced");
  a_divisor_hold: assert property (run && cp_reg >= 5'h02 && cp_reg <= 5'h12
    |-> $stable(divisor_reg))
    else $error("divisor register changed during divide");
  a_seq_idle: assert property (s_issue |-> ##20 !run)
    else $error("sequence did not return to idle");
endmodule
`default_nettype wire

// ===== testbench/fdoc_issue_model.sv
// issue side model: pulses begin with its operands, then moves the operand bus on
`timescale 1ns/1ps
`default_nettype none
module fdoc_issue_model (
  // clock and request from the bench
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic round_i,
  input wire logic [59:0] dividend_i,
  input wire logic [59:0] divisor_i,
  // issue lines toward the divider
  output logic begin_o,
  output logic round_o,
  output logic [59:0] dividend_o,
  output logic [59:0] divisor_o
);
  // quiet bus at time zero
  initial begin
    begin_o = 1'b0;
    round_o = 1'b0;
    dividend_o = 60'h0;
    divisor_o = 60'h0;
  end
  // operands stand in the issue cycle only; later the bus shows other words
  always @(posedge clk_i) begin
    begin_o <= go_i;
    round_o <= go_i & round_i;
    if (go_i) begin
      dividend_o <= dividend_i;
      divisor_o <= divisor_i;
    end else begin
      dividend_o <= ~dividend_o;
      divisor_o <= ~divisor_o;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/float_divide_output_control_tb.sv
// self-checking bench of the divide output control
`timescale 1ns/1ps
`default_nettype none
module float_divide_output_control_tb;
  import fdoc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic go = 1'b0, round = 1'b0, special = 1'b0, indef = 1'b0;
  // set when the control register forces rounding on every divide
  logic frc = 1'b0;
  logic [59:0] dvd = 60'h0, dvs = 60'h0;
  logic [2:0] digit = 3'h0;
  logic [47:0] rem_held = 48'h0;
  logic [10:0] exp_cmp = 11'h0;
  logic signed [12:0] exp_unb = 13'sh0;
  logic beg, rnd_w, awready, wready, bvalid, arready, rvalid;
  logic rel, circ, gate, qvalid, blk, clr;
  logic [59:0] dvd_w, dvs_w;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [47:0] rem_src;
  logic [49:0] mult3;
  logic [50:0] mult6;
  logic [5:0] corr;
  fdoc_quot_s quot;
  fdoc_flags_s flags;
  int n_errors = 0;
  int checks = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  fdoc_issue_model fdoc_issue_model_i (.clk_i(clk), .go_i(go), .round_i(round),
    .dividend_i(dvd), .divisor_i(dvs), .begin_o(beg), .round_o(rnd_w),
    .dividend_o(dvd_w), .divisor_o(dvs_w));
  fdoc_top fdoc_top_i (.SYS_CLK_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .BEGIN_I(beg), .ROUND_I(rnd_w),
    .DIVIDEND_OPERAND_I(dvd_w), .DIVISOR_OPERAND_I(dvs_w), .DIGIT_I(digit),
    .REM_HELD_I(rem_held), .EXP_CMP_I(exp_cmp), .EXP_UNB_I(exp_unb), .SPECIAL_I(special),
    .INDEF_I(indef), .RELEASE_REM_O(rel), .CIRC_REM_O(circ), .REM_SRC_O(rem_src),
    .MULT3_O(mult3), .MULT6_O(mult6), .EXPONENT_CORRECTION_O(corr), .QUOT_O(quot),
    .FLAGS_O(flags), .GATE_QUOT_O(gate), .QUOT_VALID_O(qvalid),
    .ISSUE_BLOCK_TIMING_O(blk), .CLR_BUSY_O(clr));
  // verdict and end of run
  task automatic give_verdict();
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // a wait that ran out ends the run
  task automatic bail();
    n_errors++;
    give_verdict();
  endtask
  // value comparison
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // axi4-lite write, address and data offered together
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    int i;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(negedge clk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) break;
    end
    bready <= 1'b0;
    if (i == 64) bail();
    else chk("bresp", 64'(er), 64'(r));
  endtask
  // axi4-lite read
  task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_t, r_t;
    logic [31:0] d;
    logic [1:0] r;
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(negedge clk);
      ar_t = arvalid & arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) break;
    end
    rready <= 1'b0;
    if (i == 64) bail();
    else begin
      chk("rresp", 64'(er), 64'(r));
      chk("rdata", 64'(ed), 64'(d));
    end
  endtask
  // one divide: issue, feed 17 digits, check every period up to idle
  task automatic divide(input int k, input logic rd, input logic [2:0] d0, input logic sp,
      input logic idf, input logic signed [12:0] eu);
    logic [47:0] sr, mdd, mds;
    logic [59:0] eq;
    logic [2:0] dg;
    logic bad, ovf, unf;
    int cp;
    @(posedge clk);
    go <= 1'b1;
    round <= rd;
    special <= sp;
    indef <= idf;
    exp_unb <= eu;
    exp_cmp <= 11'h123 + 11'(k);
    rem_held <= 48'h0F0F_3C3C_A5A5 ^ 48'(k);
    dvd <= {k[0], 11'h2A5, 48'h9ABC_DEF0_1234 + 48'(k)};
    dvs <= {~k[0], 11'h15A, 48'hC000_0000_0001 + 48'(k)};
    @(posedge clk);
    go <= 1'b0;
    mdd = dvd[59] ? ~dvd[47:0] : dvd[47:0];
    mds = dvs[59] ? ~dvs[47:0] : dvs[47:0];
    sr = 48'h0;
    ovf = !idf && eu > 13'sh03FF;
    unf = !idf && eu < -13'sh03FF;
    bad = sp | d0[1] | ovf | unf;
    for (cp = 0; cp < 21; cp++) begin
      @(negedge clk);
      chk("remctl", 64'({cp >= 2 && cp <= 17, cp >= 2 && cp <= 19}),
        64'({rel, circ}));
      chk("timing", 64'({cp == 15, cp == 17}), 64'({blk, clr}));
      chk("gate", 64'({cp == 18 && !bad, cp == 19}), 64'({gate, qvalid}));
      if (cp == 1) chk("rem_src", 64'(mdd), 64'(rem_src));
      if (cp == 2) chk("rem_src", 64'((rd | frc) ? {rem_held[47:15], 15'h2AAA} : rem_held),
        64'(rem_src));
      if (cp == 18) begin
        chk("mult3", 64'(50'(mds) * 50'h3), 64'(mult3));
        chk("mult6", 64'(51'(mds) * 51'h6), 64'(mult6));
      end
      if (cp == 19) begin
        eq = bad ? 60'hFFF_FFFF_FFFF_FFFF : {1'b0, ~exp_cmp, d0[0] ? {1'b1, sr[47:1]} : sr};
        chk("corr", 64'(d0[0] ? 6'h2F : 6'h30), 64'(corr));
        chk("exp", 64'(eq[59:48]), 64'(quot[59:48]));
        chk("coef", 64'(eq[47:0]), 64'(quot.coef));
        chk("flags", 64'({bad, ovf, unf, d0[1]}), 64'(flags));
      end
      @(posedge clk);
      dg = (cp == 1) ? d0 : 3'(cp * 5);
      if (cp >= 1 && cp <= 17) begin
        digit <= dg;
        sr = {sr[44:0], dg};
      end
    end
    axr(12'h008, eq[31:0], 2'h0);
    axr(12'h00C, {4'h0, eq[59:32]}, 2'h0);
  endtask
  // test cases: first digit, rounding, special, indefinite, unbiased exponent
  logic [2:0] t_d0 [6] = '{3'h0, 3'h1, 3'h2, 3'h0, 3'h5, 3'h1};
  logic t_rd [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic t_sp [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic t_id [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic signed [12:0] t_eu [6] = '{13'sh03FF, 13'sh1C01, 13'sh0010, 13'sh1C00, 13'sh0400,
    13'sh0400};
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    axr(12'h000, 32'h1, 2'h0);
    axr(12'h010, 32'h0, 2'h2);
    axw(12'h014, 32'h0, 2'h2);
    axw(12'h000, 32'h0, 2'h0);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (22) begin
      @(negedge clk);
      chk("idle", 64'h0, 64'({rel, circ, qvalid}));
    end
    axw(12'h000, 32'h1, 2'h0);
    for (int i = 0; i < 6; i++) begin
      divide(i, t_rd[i], t_d0[i], t_sp[i], t_id[i], t_eu[i]);
    end
    // forced rounding from the control register with an unrounded issue
    frc = 1'b1;
    axw(12'h000, 32'h3, 2'h0);
    axr(12'h000, 32'h3, 2'h0);
    divide(6, 1'b0, 3'h4, 1'b0, 1'b0, 13'sh0100);
    give_verdict();
  end
endmodule
`default_nettype wire
